/* File: rtl/servo_seek_map.svh */
// constants for the disk servo seek control block
`ifndef SERVO_SEEK_MAP_SVH
`define SERVO_SEEK_MAP_SVH

`define CLK_HZ            20000000
`define SETTLE_S          4
`define SPEED_LIMIT_S     30
`define GB_GONE_MS        500
`define HOME_S            3
`define VTEST_MAX_SEEKS   7'h40
`define LOAD_MAX_TRIES    3'h5
`define RETRY_TRAP        3'h6
`define ERR_CNT_W         4
`define ADJ_PULSE_CYC     8'h10
`define SEEK_CYC_PER_TRK  16'h0400

`define A_CTRL            6'h00
`define A_STATUS          6'h04
`define A_STEPS           6'h08
`define A_CYL             6'h0c
`define A_VEL             6'h10
`define A_TESTLIM         6'h14

`define CTRL_TC_RESET     0
`define CTRL_START        1
`define VEL_BASE_RST      7'h10

`endif

/* File: rtl/servo_seek_pkg.sv */
// types for the disk servo seek control block
package servo_seek_pkg;
  typedef enum logic [4:0] {
    ST_INIT, ST_SETTLE, ST_SPEED, ST_LOAD_CHK, ST_LOAD_OUTER, ST_LOAD_SPEED,
    ST_LOAD_GB_IN, ST_LOAD_GB_GONE, ST_LOAD_DZ, ST_HOME, ST_VTEST,
    ST_VADJ, ST_SEEK_TEST, ST_RTZ, ST_IDLE, ST_SEEK, ST_FINISH, ST_TRAP
  } seq_state_t;
endpackage : servo_seek_pkg

/* File: rtl/step_sync.sv */
// step pulse synchroniser, step counter and direction capture
`timescale 1ns/1ps
module step_sync (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // cable
  input  wire logic        step_in,
  input  wire logic        dir_in,
  // consumer
  input  wire logic        take_in,
  output logic      [15:0] steps_out,
  output logic             dir_out,
  output logic             step_seen_out
);
  logic       s1_q;
  logic       s2_q;
  logic       s3_q;
  logic       dir1_q;
  logic       dir2_q;
  wire        rise = s2_q & ~s3_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= 1'b0; s2_q <= 1'b0; s3_q <= 1'b0;
      dir1_q <= 1'b0; dir2_q <= 1'b0;
    end else begin
      s1_q   <= step_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      dir1_q <= dir_in;
      dir2_q <= dir1_q;
    end
  end

  // take clears pending count; a step in the same cycle still counts
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      steps_out     <= 16'h0000;
      dir_out       <= 1'b0;
      step_seen_out <= 1'b0;
    end else begin
      step_seen_out <= rise;
      if (rise) begin
        steps_out <= (take_in ? 16'h0000 : steps_out) + 16'h0001;
        dir_out   <= dir2_q;
      end else if (take_in) begin
        steps_out <= 16'h0000;
      end
    end
  end
endmodule : step_sync

/* File: rtl/tc_irq.sv */
// track crossing request latch and crossing counter
`timescale 1ns/1ps
module tc_irq (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // servo logic
  input  wire logic        cross_in,
  input  wire logic        tc_reset_in,
  input  wire logic        clr_cnt_in,
  output logic             irq_out,
  output logic      [15:0] crossings_out
);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out       <= 1'b0;
      crossings_out <= 16'h0000;
    end else begin
      // set wins over the reset so no crossing is lost
      if (cross_in)         irq_out <= 1'b1;
      else if (tc_reset_in) irq_out <= 1'b0;
      if (clr_cnt_in)       crossings_out <= 16'h0000;
      else if (cross_in)    crossings_out <= crossings_out + 16'h0001;
    end
  end
endmodule : tc_irq

/* File: rtl/servo_seek_ctrl.sv */
// disk servo and seek sequencer with wishbone status registers
//
// Functional notes
// - each synchronised step pulse adds one to the step counter
// - direction sampled on each step and kept for the seek
// - track crossing request holds until the block issues its own reset pulse one cycle later
// - seven-bit velocity magnitude plus eighth bit high for fast
// - slow velocity flag is the complement of the eighth bit
// - fine selects mode; dir line means inward or even target
// - power-on reset: current regulator on; after it, speed regulator
// - speed regulator clocked by the bus address strobe
// - servo off at start-up; load after lock and speed; end fine at zero
// - index sets the data-zone latch
// - guard band after first load disables the servo
// - time test seek; pulse velocity adjust while too slow
// - after calibration return to zero and raise ready in data zone
// - one seek-complete pulse at the end of each seek
// - lock loss at any time disables servo and drops ready
// - seek-test jumper loops seeks; an error traps
// - idle faults count errors; overflow restarts; steps start a seek
// - settle 4 s; speed not good in 30 s traps
// - velocity test up to 64 seeks, else back to speed check
// - no lock under 5 tries restarts; then load from outer restraint
// - guard band in, gone 500 ms, then data zone, else timeout
// - home velocity with 3 s timeout; track zero clears cylinder
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "servo_seek_map.svh"
module servo_seek_ctrl #(
  parameter int unsigned SETTLE_CYC = `SETTLE_S * `CLK_HZ,
  parameter int unsigned SPEED_CYC  = `SPEED_LIMIT_S * `CLK_HZ,
  parameter int unsigned GB_CYC     = `GB_GONE_MS * (`CLK_HZ / 1000),
  parameter int unsigned HOME_CYC   = `HOME_S * `CLK_HZ,
  parameter int unsigned STEP_TO    = 32'd40000000
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // command cable
  input  wire logic        step_in,
  input  wire logic        dir_in,
  // servo and drive status
  input  wire logic        cross_in,
  input  wire logic        plo_lock_in,
  input  wire logic        speed_ok_in,
  input  wire logic        guard_band_in,
  input  wire logic        index_in,
  input  wire logic        on_center_in,
  input  wire logic        track_zero_in,
  input  wire logic        seek_test_n_in,
  input  wire logic        addr_strobe_in,
  // servo and motor outputs
  output logic      [7:0]  velocity_out,
  output logic             slow_velocity_flag_out,
  output logic             fine_out,
  output logic             in_even_out,
  output logic             servo_disable_out,
  output logic             current_reg_en_out,
  output logic             speed_reg_en_out,
  output logic             speed_reg_clk_out,
  output logic             vel_adjust_out,
  output logic             tc_reset_out,
  output logic             tc_irq_out,
  output logic             ready_out,
  output logic             seek_comp_out,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  ////////////////////////////////////////////////////////////////////////
  servo_seek_pkg::seq_state_t st_q, st_d;
  logic [31:0] tmr_q;
  logic [31:0] tmr2_q;
  logic [2:0]  tries_q;
  logic [6:0]  vseeks_q;
  logic [`ERR_CNT_W-1:0] err_q;
  logic [6:0]  vbase_q;
  logic [15:0] cyl_q;
  logic [15:0] target_q;
  logic [15:0] test_lim_q;
  logic        loaded_q;
  logic        dz_q;
  logic        gb_latch_q;
  logic        seek_dir_q;
  logic        tc_cmd_q;
  logic        start_req_q;
  logic        test_seek_q;
  logic [15:0] steps;
  logic [15:0] crossings;
  logic        dir_cap;
  logic        step_seen;
  logic        irq;

  wire go        = st_d != st_q;
  wire in_seek   = (st_q == servo_seek_pkg::ST_SEEK);
  wire in_load   = (st_q >= servo_seek_pkg::ST_LOAD_CHK) && (st_q <= servo_seek_pkg::ST_HOME);
  wire status_ok = plo_lock_in & dz_q & ~gb_latch_q & speed_ok_in;
  wire take      = (st_q == servo_seek_pkg::ST_IDLE) && status_ok && (steps != 16'h0000);
  wire seek_done = in_seek && (crossings >= (target_q > cyl_q ? target_q - cyl_q
                                                              : cyl_q - target_q));
  wire seek_late = in_seek && (tmr_q >= STEP_TO);
  wire vtest_fast = tmr_q < {16'h0000, test_lim_q} * {16'h0000, `SEEK_CYC_PER_TRK};

  step_sync u_step (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .step_in       (step_in),
    .dir_in        (dir_in),
    .take_in       (take),
    .steps_out     (steps),
    .dir_out       (dir_cap),
    .step_seen_out (step_seen)
  );

  tc_irq u_tc (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .cross_in      (cross_in),
    .tc_reset_in   (tc_cmd_q),
    .clr_cnt_in    (take | go),
    .irq_out       (irq),
    .crossings_out (crossings)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      servo_seek_pkg::ST_INIT:   st_d = servo_seek_pkg::ST_SETTLE;
      servo_seek_pkg::ST_SETTLE: if (tmr_q >= SETTLE_CYC) st_d = servo_seek_pkg::ST_SPEED;
      servo_seek_pkg::ST_SPEED:
        if (speed_ok_in) st_d = servo_seek_pkg::ST_LOAD_CHK;
        else if (tmr_q >= SPEED_CYC) st_d = servo_seek_pkg::ST_TRAP;
      servo_seek_pkg::ST_LOAD_CHK:
        if (loaded_q && (dz_q || guard_band_in)) st_d = servo_seek_pkg::ST_INIT;
        else if (plo_lock_in) st_d = servo_seek_pkg::ST_LOAD_SPEED;
        else if (tries_q < `LOAD_MAX_TRIES - 3'h1) st_d = servo_seek_pkg::ST_INIT;
        else st_d = servo_seek_pkg::ST_LOAD_OUTER;
      servo_seek_pkg::ST_LOAD_OUTER:
        if (plo_lock_in) st_d = servo_seek_pkg::ST_LOAD_SPEED;
        else if (tmr_q >= HOME_CYC) st_d = servo_seek_pkg::ST_TRAP;
      servo_seek_pkg::ST_LOAD_SPEED:
        if (speed_ok_in) st_d = servo_seek_pkg::ST_LOAD_GB_IN;
        else if (&err_q) st_d = servo_seek_pkg::ST_TRAP;
      servo_seek_pkg::ST_LOAD_GB_IN:
        if (guard_band_in) st_d = servo_seek_pkg::ST_LOAD_GB_GONE;
        else if (tmr_q >= HOME_CYC) st_d = servo_seek_pkg::ST_INIT;
      servo_seek_pkg::ST_LOAD_GB_GONE:
        if (tmr2_q >= GB_CYC) st_d = servo_seek_pkg::ST_LOAD_DZ;
        else if (tmr_q >= HOME_CYC) st_d = servo_seek_pkg::ST_INIT;
      servo_seek_pkg::ST_LOAD_DZ:
        if (dz_q) st_d = servo_seek_pkg::ST_HOME;
        else if (tmr_q >= HOME_CYC) st_d = servo_seek_pkg::ST_INIT;
      servo_seek_pkg::ST_HOME:
        if (!plo_lock_in || tmr_q >= HOME_CYC) st_d = servo_seek_pkg::ST_INIT;
        else if (track_zero_in) st_d = servo_seek_pkg::ST_VTEST;
      servo_seek_pkg::ST_VTEST:
        if (vseeks_q >= `VTEST_MAX_SEEKS) st_d = servo_seek_pkg::ST_SPEED;
        else if (on_center_in && tmr_q > 32'd1)
          st_d = vtest_fast ? (!seek_test_n_in ? servo_seek_pkg::ST_SEEK_TEST
                                               : servo_seek_pkg::ST_RTZ)
                            : servo_seek_pkg::ST_VADJ;
      servo_seek_pkg::ST_VADJ:
        // leave one count early: the registered pulse then stands the full adjust count
        if (tmr_q >= {24'h000000, `ADJ_PULSE_CYC} - 32'h00000001)
          st_d = servo_seek_pkg::ST_VTEST;
      servo_seek_pkg::ST_SEEK_TEST:
        if (!plo_lock_in || gb_latch_q) st_d = servo_seek_pkg::ST_TRAP;
        else if (seek_test_n_in) st_d = servo_seek_pkg::ST_RTZ;
      servo_seek_pkg::ST_RTZ:
        if (track_zero_in) st_d = servo_seek_pkg::ST_IDLE;
        else if (tmr_q >= HOME_CYC) st_d = servo_seek_pkg::ST_INIT;
      servo_seek_pkg::ST_IDLE:
        if (&err_q) st_d = servo_seek_pkg::ST_INIT;
        else if (take || start_req_q) st_d = servo_seek_pkg::ST_SEEK;
      servo_seek_pkg::ST_SEEK:
        if (seek_done || seek_late) st_d = servo_seek_pkg::ST_FINISH;
      servo_seek_pkg::ST_FINISH: st_d = servo_seek_pkg::ST_IDLE;
      servo_seek_pkg::ST_TRAP:   st_d = servo_seek_pkg::ST_TRAP;  // only power cycling leaves
      default:                   st_d = servo_seek_pkg::ST_INIT;
    endcase
    if (!plo_lock_in && st_q >= servo_seek_pkg::ST_IDLE && st_q != servo_seek_pkg::ST_TRAP)
      st_d = servo_seek_pkg::ST_INIT;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q   <= servo_seek_pkg::ST_INIT;
      tmr_q  <= 32'h00000000;
      tmr2_q <= 32'h00000000;
    end else begin
      st_q   <= st_d;
      tmr_q  <= go ? 32'h00000000 : tmr_q + 32'h00000001;
      tmr2_q <= (go || guard_band_in) ? 32'h00000000 : tmr2_q + 32'h00000001;
    end
  end

  // counters and latches of the sequence
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tries_q <= 3'h0; vseeks_q <= 7'h00; err_q <= '0; vbase_q <= `VEL_BASE_RST;
      cyl_q <= 16'h0000; target_q <= 16'h0000; loaded_q <= 1'b0; dz_q <= 1'b0;
      gb_latch_q <= 1'b0; seek_dir_q <= 1'b1;
    end else begin
      if (st_q == servo_seek_pkg::ST_LOAD_CHK && go && st_d == servo_seek_pkg::ST_INIT)
        tries_q <= tries_q + 3'h1;
      if (st_q == servo_seek_pkg::ST_HOME && go)
        vseeks_q <= 7'h00;
      else if (st_q == servo_seek_pkg::ST_VTEST && go) begin
        vseeks_q <= vseeks_q + 7'h01;
        vbase_q  <= vbase_q + 7'h01;
      end
      if ((st_q == servo_seek_pkg::ST_IDLE && !status_ok) ||
          (st_q == servo_seek_pkg::ST_LOAD_SPEED && !speed_ok_in))
        err_q <= err_q + 1'b1;
      else if (go) err_q <= '0;
      if (index_in) dz_q <= 1'b1;
      else if (guard_band_in || st_q == servo_seek_pkg::ST_INIT) dz_q <= 1'b0;
      if (guard_band_in && loaded_q) gb_latch_q <= 1'b1;
      else if (st_q == servo_seek_pkg::ST_INIT) gb_latch_q <= 1'b0;
      if (st_q == servo_seek_pkg::ST_HOME && st_d == servo_seek_pkg::ST_VTEST) begin
        cyl_q    <= 16'h0000;
        loaded_q <= 1'b1;
      end else if (st_q == servo_seek_pkg::ST_RTZ && track_zero_in) cyl_q <= 16'h0000;
      else if (st_q == servo_seek_pkg::ST_FINISH) cyl_q <= target_q;
      if (take) begin
        seek_dir_q <= dir_cap;
        target_q   <= dir_cap ? cyl_q + steps : (steps > cyl_q ? 16'h0000 : cyl_q - steps);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  wire       fast    = in_seek || st_q == servo_seek_pkg::ST_VTEST ||
                       st_q == servo_seek_pkg::ST_SEEK_TEST;
  wire [6:0] mag     = in_seek ? 7'h7f : (fast ? vbase_q : 7'h08);
  wire       moving  = in_seek || in_load || st_q == servo_seek_pkg::ST_VTEST ||
                       st_q == servo_seek_pkg::ST_SEEK_TEST || st_q == servo_seek_pkg::ST_RTZ;
  wire       srv_off = st_q <= servo_seek_pkg::ST_LOAD_CHK || st_q == servo_seek_pkg::ST_TRAP ||
                       gb_latch_q || !plo_lock_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      velocity_out <= 8'h00; slow_velocity_flag_out <= 1'b1; fine_out <= 1'b0;
      in_even_out <= 1'b1; servo_disable_out <= 1'b1; current_reg_en_out <= 1'b1;
      speed_reg_en_out <= 1'b0; speed_reg_clk_out <= 1'b0; vel_adjust_out <= 1'b0;
      tc_cmd_q <= 1'b0; tc_irq_out <= 1'b0; ready_out <= 1'b0; seek_comp_out <= 1'b0;
    end else begin
      velocity_out           <= moving ? {fast, mag} : 8'h00;
      slow_velocity_flag_out <= ~(moving & fast);
      fine_out               <= ~moving;
      in_even_out            <= moving ? seek_dir_q : ~target_q[0];
      servo_disable_out      <= srv_off;
      current_reg_en_out     <= 1'b0;
      speed_reg_en_out       <= 1'b1;
      speed_reg_clk_out      <= addr_strobe_in;
      vel_adjust_out         <= st_q == servo_seek_pkg::ST_VADJ;
      tc_cmd_q               <= irq & ~tc_cmd_q;
      tc_irq_out             <= irq;
      ready_out              <= (st_q == servo_seek_pkg::ST_IDLE) & dz_q &
                                plo_lock_in & ~gb_latch_q;
      seek_comp_out          <= st_q == servo_seek_pkg::ST_FINISH;
    end
  end
  assign tc_reset_out = tc_cmd_q;

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack drops after one cycle
  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr_ctl = wb_req & wb_we_i & (wb_adr_i == `A_CTRL) & wb_sel_i[0];
  wire        wr_lim = wb_req & wb_we_i & (wb_adr_i == `A_TESTLIM);
  wire [31:0] rd_mux = (wb_adr_i == `A_STATUS)  ? {22'h000000, st_q, ready_out, dz_q,
                                                   gb_latch_q, loaded_q, dir_cap} :
                       (wb_adr_i == `A_STEPS)   ? {16'h0000, steps} :
                       (wb_adr_i == `A_CYL)     ? {16'h0000, cyl_q} :
                       (wb_adr_i == `A_VEL)     ? {24'h000000, velocity_out} :
                       (wb_adr_i == `A_TESTLIM) ? {16'h0000, test_lim_q} : 32'h00000000;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_o <= 1'b0; wb_dat_o <= 32'h00000000;
      test_lim_q <= 16'h0040; start_req_q <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h00000000;
      if (wr_lim) test_lim_q <= wb_dat_i[15:0];
      if (wr_ctl && wb_dat_i[`CTRL_START]) start_req_q <= 1'b1;
      else if (in_seek) start_req_q <= 1'b0;
    end
  end
endmodule : servo_seek_ctrl

/* File: verif/servo_seek_ctrl_checker.sv */
// port assertions for the servo seek control block
`timescale 1ns/1ps
module servo_seek_ctrl_checker (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       nrst_in,
  // watched inputs
  input wire logic       cross_in,
  input wire logic       plo_lock_in,
  input wire logic       addr_strobe_in,
  // watched outputs
  input wire logic [7:0] velocity_out,
  input wire logic       slow_velocity_flag_out,
  input wire logic       fine_out,
  input wire logic       servo_disable_out,
  input wire logic       current_reg_en_out,
  input wire logic       speed_reg_en_out,
  input wire logic       speed_reg_clk_out,
  input wire logic       vel_adjust_out,
  input wire logic       tc_reset_out,
  input wire logic       tc_irq_out,
  input wire logic       ready_out,
  input wire logic       seek_comp_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // length of the running adjust pulse
  logic [7:0] adj_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) adj_q <= 8'h00;
    else adj_q <= vel_adjust_out ? adj_q + 8'h01 : 8'h00;
  end
  property p_slow;
    velocity_out != 8'h00 |-> slow_velocity_flag_out == !velocity_out[7];
  endproperty
  a_slow: assert property (p_slow) else $error("slow flag disagrees with fast bit");
  property p_regs; current_reg_en_out != speed_reg_en_out; endproperty
  a_regs: assert property (p_regs) else $error("both or no spindle regulators on");
  property p_aclk; $past(nrst_in) |-> speed_reg_clk_out == $past(addr_strobe_in); endproperty
  a_aclk: assert property (p_aclk) else $error("speed regulator clock not the strobe");
  property p_irq_set; cross_in |-> ##2 tc_irq_out; endproperty
  a_irq_set: assert property (p_irq_set) else $error("crossing raised no request");
  property p_irq_hold;
    $fell(tc_irq_out) |-> $past(tc_reset_out) || $past(tc_reset_out, 2);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped without reset");
  property p_adj; $fell(vel_adjust_out) |-> adj_q == 8'h10; endproperty
  a_adj: assert property (p_adj) else $error("adjust pulse length wrong");
  property p_comp; seek_comp_out |=> !seek_comp_out; endproperty
  a_comp: assert property (p_comp) else $error("seek complete longer than a pulse");
  property p_lock; !plo_lock_in [*2] |-> ##[0:3] (servo_disable_out && !ready_out); endproperty
  a_lock: assert property (p_lock) else $error("lock loss left servo on");
  property p_ready; ready_out |-> fine_out && !servo_disable_out; endproperty
  a_ready: assert property (p_ready) else $error("ready while not on cylinder");
endmodule : servo_seek_ctrl_checker
bind servo_seek_ctrl servo_seek_ctrl_checker chk (.clk_in, .nrst_in, .cross_in, .plo_lock_in,
  .addr_strobe_in, .velocity_out, .slow_velocity_flag_out, .fine_out, .servo_disable_out,
  .current_reg_en_out, .speed_reg_en_out, .speed_reg_clk_out, .vel_adjust_out,
  .tc_reset_out, .tc_irq_out, .ready_out, .seek_comp_out);

/* File: verif/step_cable_host.sv */
// controller end of the step and direction cable
`timescale 1ns/1ps
module step_cable_host (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // bench command
  input  wire logic       go_in,
  input  wire logic [7:0] count_in,
  input  wire logic       dir_req_in,
  // cable
  output logic            step_out,
  output logic            dir_out,
  output logic            busy_out
);
  logic [7:0] left_q;
  logic [2:0] ph_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      left_q <= 8'h00;
      ph_q <= 3'h0;
      step_out <= 1'b0;
      dir_out <= 1'b0;
    end else if (left_q == 8'h00) begin
      step_out <= 1'b0;
      ph_q <= 3'h0;
      if (go_in) left_q <= count_in;
      if (go_in) dir_out <= dir_req_in;
    end else begin
      // two cycles high, six low: slow enough for the synchroniser
      ph_q <= ph_q + 3'h1;
      step_out <= ph_q < 3'h2;
      if (ph_q == 3'h7) left_q <= left_q - 8'h01;
    end
  end
  assign busy_out = left_q != 8'h00;
endmodule : step_cable_host

/* File: verif/disk_servo_seek_control_tb_top.sv */
// self-checking bench for the servo seek control block
`timescale 1ns/1ps
`include "servo_seek_map.svh"
module disk_servo_seek_control_tb_top;
  logic        clk_in, nrst_in, step_in, dir_in, cross_in, plo_lock_in, speed_ok_in;
  logic        guard_band_in, index_in, on_center_in, track_zero_in, seek_test_n_in;
  logic        addr_strobe_in, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go, dreq, busy;
  logic        slow_velocity_flag_out, fine_out, in_even_out, servo_disable_out;
  logic        current_reg_en_out, speed_reg_en_out, speed_reg_clk_out, vel_adjust_out;
  logic        tc_reset_out, tc_irq_out, ready_out, seek_comp_out;
  logic [7:0]  velocity_out, cnt;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          n_mismatch, checked;
  servo_seek_ctrl #(.SETTLE_CYC(100), .SPEED_CYC(2000), .GB_CYC(50), .HOME_CYC(1000),
    .STEP_TO(500)) DUT (.clk_in, .nrst_in, .step_in, .dir_in, .cross_in, .plo_lock_in,
    .speed_ok_in, .guard_band_in, .index_in, .on_center_in, .track_zero_in, .seek_test_n_in,
    .addr_strobe_in, .velocity_out, .slow_velocity_flag_out, .fine_out, .in_even_out,
    .servo_disable_out, .current_reg_en_out, .speed_reg_en_out, .speed_reg_clk_out,
    .vel_adjust_out, .tc_reset_out, .tc_irq_out, .ready_out, .seek_comp_out, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  step_cable_host host (.clk_in, .nrst_in, .go_in(go), .count_in(cnt), .dir_req_in(dreq),
    .step_out(step_in), .dir_out(dir_in), .busy_out(busy));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) n_mismatch++;
    if (g !== e) $display("[FAIL] %s expected %h seen %h", nm, e, g);
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_n
  // classic single cycle; the answer is awaited, never assumed
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hf, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    chk("wb ack", 32'h1, 32'(n < 20));
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic do_reset;
    nrst_in <= 1'b0;
    wait_n(2);
    nrst_in <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_strobe;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      addr_strobe_in <= i[0] ^ i[1];
      wait_n(2);
      chk("speed_reg_clk", 32'(i[0] ^ i[1]), 32'(speed_reg_clk_out));
    end
  endtask : t_strobe
  task automatic t_steps(input logic [7:0] n, input logic d, input logic [31:0] total);
    @(posedge clk_in);
    {go, cnt, dreq} <= {1'b1, n, d};
    @(posedge clk_in);
    go <= 1'b0;
    // the host loaded its count at the edge above; busy, decoded from it, is already high
    @(posedge clk_in);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk_in);
    wait_n(6);
    wb(1'b0, `A_STEPS, 32'h0);
    chk("steps", total, rd);
    wb(1'b0, `A_STATUS, 32'h0);
    chk("dir", 32'(d), rd & 32'h1);
  endtask : t_steps
  task automatic t_cross;
    @(posedge clk_in);
    cross_in <= 1'b1;
    @(posedge clk_in);
    cross_in <= 1'b0;
    wait_n(2);
    chk("tc_irq", 32'h1, 32'(tc_irq_out));
  endtask : t_cross
  // load, calibrate, seek the pending steps, then lose lock
  task automatic t_load;
    {speed_ok_in, guard_band_in} <= 2'b11;
    wait_n(20);
    guard_band_in <= 1'b0;
    wait_n(70);
    chk("fast bit", 32'h0, 32'(velocity_out[7]));
    chk("slow flag", 32'h1, 32'(slow_velocity_flag_out));
    chk("coarse", 32'h0, 32'(fine_out));
    chk("servo on", 32'h0, 32'(servo_disable_out));
    {index_in, track_zero_in, on_center_in} <= 3'b111;
    for (int i = 0; i < 50 && seek_comp_out !== 1'b1; i++) @(posedge clk_in);
    chk("seek_comp", 32'h1, 32'(seek_comp_out));
    wait_n(2);
    chk("ready", 32'h1, 32'(ready_out));
    chk("fine", 32'h1, 32'(fine_out));
    chk("even", 32'h1, 32'(in_even_out));
    wb(1'b0, `A_STEPS, 32'h0);
    chk("steps taken", 32'h0, rd);
    plo_lock_in <= 1'b0;
    wait_n(3);
    chk("ready lost", 32'h0, 32'(ready_out));
    chk("servo off", 32'h1, 32'(servo_disable_out));
    {plo_lock_in, speed_ok_in, index_in, track_zero_in, on_center_in} <= 5'h10;
  endtask : t_load
  task automatic t_regs;
    wb(1'b0, `A_TESTLIM, 32'h0);
    chk("testlim rst", 32'h40, rd);
    wb(1'b1, `A_TESTLIM, 32'h25);
    wb(1'b0, `A_TESTLIM, 32'h0);
    chk("testlim", 32'h25, rd);
    wb(1'b1, `A_STEPS, 32'h0);
    wb(1'b0, `A_STEPS, 32'h0);
    chk("steps ro", 32'h8, rd);
    wb(1'b1, 6'h3c, 32'hffff);
    wb(1'b0, 6'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask : t_regs
  // speed not good within the limit: trap after settle plus limit, and it holds once speed is good
  task automatic t_trap;
    logic [31:0] trap;
    trap = 32'(servo_seek_pkg::ST_TRAP);
    do_reset();
    // the release edge still resets; the next one launches the run values
    wait_n(2);
    chk("current_reg after", 32'h0, 32'(current_reg_en_out));
    chk("speed_reg after", 32'h1, 32'(speed_reg_en_out));
    wait_n(1900);
    wb(1'b0, `A_STATUS, 32'h0);
    chk("early trap", 32'h0, 32'((rd >> 5 & 32'h1f) == trap));
    wait_n(500);
    speed_ok_in <= 1'b1;
    wait_n(200);
    wb(1'b0, `A_STATUS, 32'h0);
    chk("trap", trap, rd >> 5 & 32'h1f);
    plo_lock_in <= 1'b0;
    wait_n(6);
    chk("servo_disable", 32'h1, 32'(servo_disable_out));
    chk("ready", 32'h0, 32'(ready_out));
  endtask : t_trap
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst_in, cross_in, speed_ok_in, guard_band_in, index_in, on_center_in} = 6'h00;
    {track_zero_in, addr_strobe_in, wb_cyc_i, wb_stb_i, wb_we_i, go, dreq} = 7'h00;
    {plo_lock_in, seek_test_n_in, wb_adr_i, wb_sel_i, wb_dat_i, cnt} = {2'b11, 50'h0f};
    n_mismatch = 0;
    checked = 0;
    #60;
    chk("current_reg in rst", 32'h1, 32'(current_reg_en_out));
    chk("speed_reg in rst", 32'h0, 32'(speed_reg_en_out));
    chk("servo_disable rst", 32'h1, 32'(servo_disable_out));
    @(posedge clk_in);
    nrst_in <= 1'b1;
    t_strobe();
    t_steps(8'h05, 1'b1, 32'h5);
    t_steps(8'h03, 1'b0, 32'h8);
    t_cross();
    t_regs();
    t_load();
    t_trap();
    report_and_stop();
  end
  initial begin
    #(50 * 20000);
    n_mismatch++;
    report_and_stop();
  end
endmodule : disk_servo_seek_control_tb_top
